/* File: common/tick_timer_pkg.sv */
/*
 * constants and carrier types for the system tick down counter:
 * register offsets, field positions, reset values and response codes.
 * assumes a 32-bit axi4-lite register bus with word-aligned registers.
 */
package tick_timer_pkg;

    // register byte offsets
    localparam logic [3:0] off_control = 4'h0;
    localparam logic [3:0] off_reload = 4'h4;
    localparam logic [3:0] off_current = 4'h8;
    localparam logic [3:0] off_clock_select = 4'hC;

    // field positions in tick_control_register
    localparam int pos_enable = 0;
    localparam int pos_source = 2;
    localparam int pos_wrap_seen = 16;

    // field position of external_tick_source_select in clock_select_register_zero
    localparam int pos_ext_sel_lo = 3;
    localparam int ext_sel_width = 3;
    localparam int ext_source_count = 4;

    // reset values
    localparam logic [31:0] reset_reload = 32'h0000_0000;
    localparam logic [31:0] reset_count = 32'h0000_0000;
    localparam logic [2:0] reset_ext_sel = 3'h0;

    // axi response codes
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // software-controlled fields of the control register
    typedef struct packed {
        logic enable;
        logic use_core_clock;
    } control_type;

    // one buffered axi write request
    typedef struct packed {
        logic addr_valid;
        logic [3:0] addr;
        logic data_valid;
        logic [31:0] data;
    } write_hold_type;

endpackage

/* File: hw/system_tick_down_counter.sv */
/*
 * system tick down counter with an axi4-lite register slave.
 * holds the counter, the reload value, the wrap-seen flag and the
 * external tick source selection.
 * assumes external tick inputs are synchronous to aclk; each rising
 * level change on the selected input is one count tick.
 * assumes a bus master that keeps at most one write and one read open.
 *
 * behaviour a user must know:
 * - write strobes are ignored; every write replaces the whole register.
 * - an address that is not a multiple of four answers with slverr;
 *   such a read returns zero and such a write changes nothing.
 * - the write response comes one cycle after both beats are held, so
 *   two cycles after the later of address and data is taken.
 * - the read answer comes one cycle after the address is taken.
 * - a write to the current value wins over a tick in the same cycle.
 * - a wrap in the same cycle as the clearing read keeps the flag set,
 *   so software never loses a wrap between two reads.
 * - a source select of four or above picks no input; the count stalls unless the core clock is selected.
 * - the counter resets to zero, though software must not rely on it.
 */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module system_tick_down_counter
    import tick_timer_pkg::*;
#(
    parameter int count_width = 24
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // external tick sources
    input wire logic [ext_source_count-1:0] external_tick_clock,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // the control register is laid out for a counter of at most 24 bits
    if (count_width < 1 || count_width > 24) begin : g_bad_width
        $error("count_width must be 1..24");
    end

    // the source index below is two bits wide; more inputs would alias
    if (ext_source_count < 1 || ext_source_count > 4) begin : g_bad_sources
        $error("ext_source_count must be 1..4");
    end

    // register state
    control_type control, next_control;
    logic wrap_seen_flag, next_wrap_seen_flag;
    logic [count_width-1:0] reload_value_register, next_reload_value_register;
    logic [count_width-1:0] current_value_register, next_current_value_register;
    logic [ext_sel_width-1:0] external_tick_source_select, next_external_tick_source_select;
    logic [ext_source_count-1:0] tick_prev, next_tick_prev;

    // bus state
    write_hold_type wr_hold, next_wr_hold;
    logic bvalid_q, next_bvalid;
    logic [1:0] bresp_q, next_bresp;
    logic rvalid_q, next_rvalid;
    logic [1:0] rresp_q, next_rresp;
    logic [31:0] rdata_q, next_rdata;

    // derived strobes
    logic [ext_source_count-1:0] source_rise;
    logic selected_in_range;
    logic ext_rise;
    logic tick;
    logic do_write;
    logic do_read;
    logic write_mapped;
    logic read_mapped;
    logic [31:0] read_word;

    // handshake readies: one buffered beat each, none while a response is pending
    assign s_axi_awready = !wr_hold.addr_valid && !bvalid_q;
    assign s_axi_wready = !wr_hold.data_valid && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // write fires once address and data are both held
    assign do_write = wr_hold.addr_valid && wr_hold.data_valid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign write_mapped = wr_hold.addr[1:0] == 2'h0;
    assign read_mapped = s_axi_araddr[1:0] == 2'h0;

    // previous level of every external input, for the edge detectors;
    // all inputs are tracked so a change of select never sees a stale level
    always_comb begin
        next_tick_prev = external_tick_clock;
    end

    // one rising-change detector per external input
    for (genvar g = 0; g < ext_source_count; g++) begin : g_edge
        assign source_rise[g] = external_tick_clock[g] && !tick_prev[g];
    end

    // an out-of-range select picks no source at all, so the count stalls unless the core clock is selected
    assign selected_in_range =
        external_tick_source_select < ext_sel_width'(ext_source_count);

    // tick source: core clock every cycle, or a rising edge of the chosen input
    assign ext_rise = selected_in_range
        && source_rise[external_tick_source_select[1:0]];
    assign tick = control.use_core_clock ? 1'b1 : ext_rise;

    // read mux: reserved bits read as zero
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            off_control: begin
                read_word[pos_enable] = control.enable;
                read_word[pos_source] = control.use_core_clock;
                read_word[pos_wrap_seen] = wrap_seen_flag;
            end
            off_reload: read_word[count_width-1:0] = reload_value_register;
            off_current: read_word[count_width-1:0] = current_value_register;
            off_clock_select: begin
                read_word[pos_ext_sel_lo +: ext_sel_width] = external_tick_source_select;
            end
            default: read_word = 32'h0000_0000;
        endcase
    end

    // next state of the counter and its registers
    always_comb begin
        next_control = control;
        next_reload_value_register = reload_value_register;
        next_current_value_register = current_value_register;
        next_external_tick_source_select = external_tick_source_select;
        next_wrap_seen_flag = wrap_seen_flag;
        // read side effect first, so a same-cycle wrap wins below
        if (do_read && s_axi_araddr == off_control) begin
            next_wrap_seen_flag = 1'b0;
        end
        // counting; disabled holds everything
        if (control.enable && tick) begin
            if (current_value_register == '0) begin
                next_current_value_register = reload_value_register;
            end else begin
                next_current_value_register = current_value_register - 1'b1;
                if (current_value_register == count_width'(1)) begin
                    next_wrap_seen_flag = 1'b1;
                end
            end
        end
        // software writes take priority over the count step
        if (do_write) begin
            unique case (wr_hold.addr)
                off_control: begin
                    next_control.enable = wr_hold.data[pos_enable];
                    next_control.use_core_clock = wr_hold.data[pos_source];
                end
                off_reload: next_reload_value_register = wr_hold.data[count_width-1:0];
                // the written value is dropped on purpose; only zero is stored
                off_current: next_current_value_register = '0;
                off_clock_select: begin
                    next_external_tick_source_select =
                        wr_hold.data[pos_ext_sel_lo +: ext_sel_width];
                end
                default: next_control = control;
            endcase
        end
    end

    // next state of the bus slave, write side; address and data may come
    // in either order, each is parked until its partner arrives
    always_comb begin
        next_wr_hold = wr_hold;
        next_bvalid = bvalid_q;
        next_bresp = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            next_wr_hold.addr_valid = 1'b1;
            next_wr_hold.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wr_hold.data_valid = 1'b1;
            next_wr_hold.data = s_axi_wdata;
        end
        if (do_write) begin
            next_wr_hold.addr_valid = 1'b0;
            next_wr_hold.data_valid = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = write_mapped ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // next state of the bus slave, read side; data is captured at the
    // address handshake so it stands unchanged until rready
    always_comb begin
        next_rvalid = rvalid_q;
        next_rresp = rresp_q;
        next_rdata = rdata_q;
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rdata = read_word;
            next_rresp = read_mapped ? resp_okay : resp_slverr;
        end else if (s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // registers; counter reset to zero though software must not rely on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= '0;
            wrap_seen_flag <= 1'b0;
            reload_value_register <= reset_reload[count_width-1:0];
            current_value_register <= reset_count[count_width-1:0];
            external_tick_source_select <= reset_ext_sel;
            tick_prev <= '0;
            wr_hold <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= resp_okay;
            rvalid_q <= 1'b0;
            rresp_q <= resp_okay;
            rdata_q <= 32'h0000_0000;
        end else begin
            control <= next_control;
            wrap_seen_flag <= next_wrap_seen_flag;
            reload_value_register <= next_reload_value_register;
            current_value_register <= next_current_value_register;
            external_tick_source_select <= next_external_tick_source_select;
            tick_prev <= next_tick_prev;
            wr_hold <= next_wr_hold;
            bvalid_q <= next_bvalid;
            bresp_q <= next_bresp;
            rvalid_q <= next_rvalid;
            rresp_q <= next_rresp;
            rdata_q <= next_rdata;
        end
    end

endmodule

`default_nettype wire

/* File: sim/system_tick_down_counter_checker.sv */
/* bus assertions for the tick counter, bound to its top module.
   assumes one aclk domain, synchronous active-low aresetn. */
`timescale 1ns/1ns
`default_nettype none
module system_tick_down_counter_checker
    import tick_timer_pkg::*;
#(
    parameter int count_width = 24
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] rd_addr;
    logic [3:0] next_rd_addr;
    // remember which register the answered read came from
    always_comb begin
        next_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr;
    end
    always_ff @(posedge aclk) begin
        rd_addr <= next_rd_addr;
    end
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid) else $error("read late");
    write_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid) else $error("write late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar accepted");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("aw or w accepted");
    count_width_a: assert property (s_axi_rvalid && rd_addr == off_current |->
        s_axi_rdata[31:count_width] == '0) else $error("count too wide");
    unmapped_read_a: assert property (s_axi_rvalid && rd_addr[1:0] != 2'b00 |->
        s_axi_rresp == resp_slverr && s_axi_rdata == '0) else $error("unmapped read");
endmodule
bind system_tick_down_counter system_tick_down_counter_checker #(
    .count_width(count_width)
) system_tick_down_counter_checker_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

/* File: sim/system_tick_down_counter_tb.sv */
/* self-checking bench for the tick counter: register bus and tick inputs.
   assumes one 250 MHz clock and seeded $urandom stimulus. */
`timescale 1ns/1ns
`default_nettype none
module system_tick_down_counter_tb;
    import tick_timer_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [3:0] ext = 4'h0, awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic awr, wr_rdy, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, last;
    int errors = 0;
    int samples_checked = 0;
    always #2 aclk = ~aclk;
    system_tick_down_counter system_tick_down_counter_inst (
        .aclk(aclk), .aresetn(aresetn), .external_tick_clock(ext),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
    );
    task automatic tally_and_finish();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, got);
        end
    endtask
    // a hung handshake ends the run at once
    task automatic bound(input int n);
        if (n >= 200) begin
            chk("handshake", 0, 1);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'($urandom);
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
            if (!br) br <= 1'($urandom);
        end while (!(bv === 1'b1 && br === 1'b1) && n < 200);
        bound(n);
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    // compares masked read data; the raw word stays in last
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
        int n = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'($urandom);
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
            if (!rr) rr <= 1'($urandom);
        end while (!(rv === 1'b1 && rr === 1'b1) && n < 200);
        last = rdata;
        bound(n);
        chk("rdata", e, rdata & m);
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    // one rising change on source s, noise on the others
    task automatic pulse(input int s);
        ext <= 4'($urandom) | (4'h1 << s);
        @(posedge aclk);
        ext <= 4'($urandom) & ~(4'h1 << s);
        @(posedge aclk);
    endtask
    // first tick from zero reloads, later ones count down
    function automatic logic [31:0] after_ticks(input logic [23:0] rl, input int k);
        return {8'h00, rl - 24'(k - 1)};
    endfunction
    initial begin
        logic [23:0] rl;
        int k;
        void'($urandom(31172));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(off_control, 32'h0000_0000, '1, resp_okay);
        rd(off_current, 32'h0000_0000, '1, resp_okay);
        rd(4'h6, 32'h0000_0000, '1, resp_slverr);
        wr(4'h2, 32'hFFFF_FFFF, resp_slverr);
        for (int s = 0; s < ext_source_count; s++) begin
            ext <= 4'h0;
            rl = 24'($urandom) | 24'h00_0010;
            k = 2 + int'($urandom % 6);
            wr(off_control, 32'h0000_0000, resp_okay);
            wr(off_reload, {8'h00, rl}, resp_okay);
            wr(off_current, $urandom, resp_okay);
            rd(off_current, 32'h0000_0000, '1, resp_okay);
            wr(off_clock_select, 32'(s) << pos_ext_sel_lo, resp_okay);
            wr(off_control, 32'h0000_0001, resp_okay);
            repeat (k) pulse(s);
            rd(off_current, after_ticks(rl, k), '1, resp_okay);
            wr(off_control, 32'h0000_0000, resp_okay);
            pulse(s);
            rd(off_current, after_ticks(rl, k), '1, resp_okay);
        end
        // core clock: count falls, wraps, flag clears on read
        rl = 24'd300 + 24'($urandom % 500);
        wr(off_reload, {8'h00, rl}, resp_okay);
        wr(off_current, 32'h0000_0000, resp_okay);
        wr(off_control, 32'h0000_0005, resp_okay);
        repeat (rl / 2) @(posedge aclk);
        rd(off_current, 32'h0000_0000, 32'hFF00_0000, resp_okay);
        k = int'(last);
        rd(off_current, 32'h0000_0000, 32'h0000_0000, resp_okay);
        chk("count falls", 1, 32'(last < 32'(k)));
        repeat (rl) @(posedge aclk);
        wr(off_control, 32'h0000_0004, resp_okay);
        rd(off_control, 32'h0001_0004, '1, resp_okay);
        rd(off_control, 32'h0000_0004, '1, resp_okay);
        rd(off_current, 32'h0000_0000, 32'h0000_0000, resp_okay);
        k = int'(last);
        repeat (50) @(posedge aclk);
        rd(off_current, 32'(k), '1, resp_okay);
        // zero reload parks the count while still enabled
        wr(off_reload, 32'h0000_0000, resp_okay);
        wr(off_control, 32'h0000_0005, resp_okay);
        repeat (k + 20) @(posedge aclk);
        rd(off_current, 32'h0000_0000, '1, resp_okay);
        rd(off_control, 32'h0000_0005, 32'h0000_0005, resp_okay);
        tally_and_finish();
    end
endmodule
`default_nettype wire
